// *** hw/icl_unit.sv ***
// APB-reached integer compare and bitwise logic unit with its condition register
//
// Contract
// - signed compares test the first operand against the sign-extended immediate or the second operand as two's-complement numbers.
// - unsigned compares test the first operand against the immediate or the second operand as magnitudes.
// - the unsigned immediate compare widens the 16-bit immediate with sixteen leading zeros.
// - a compare writes only the selected condition field and leaves the other seven alone.
// - the size bit of a compare is ignored and all 32 bits are always compared.
// - the 3-bit field selector picks one of condition fields zero to seven.
// - bitwise ops with update, and always the low and high immediate AND, set field zero from the result tested signed against zero.
// - bitwise ops without update, the immediate OR and XOR among them, leave the condition register alone.
// - no bitwise op touches the summary-overflow, overflow or carry bits.
// - low immediate AND, OR, XOR zero-extend the immediate, combine with the source and write the result.
// - high immediate AND, OR, XOR put the immediate in the top half over sixteen zeros, combine and write the result.
// - register AND, OR, XOR combine both sources bit by bit and write the 32-bit result.
// - NAND and NOR invert the AND or OR of both sources before writing it.
// - the record bit of register bitwise forms chooses whether field zero is updated.
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
module icl_unit (
    input  wire logic        pclk,     // core clock, 250 MHz
    input  wire logic        presetn,  // asynchronous reset, active low
    input  wire logic        psel,     // apb select
    input  wire logic        penable,  // apb access phase
    input  wire logic        pwrite,   // apb direction, high writes
    input  wire logic [7:0]  paddr,    // apb byte address
    input  wire logic [31:0] pwdata,   // apb write data
    output logic      [31:0] prdata,   // apb read data
    output logic             pready,   // apb ready
    output logic             pslverr   // apb error on unmapped address
);

    // ****************************************
    // apb decode
    // ****************************************
    logic [31:0]      opnd_a_q;
    logic [31:0]      opnd_b_q;
    icl_pkg::icl_cmd_s cmd_q;
    logic [31:0]      result_q;
    logic [31:0]      cond_reg_q;
    logic [2:0]       fxer_q;
    logic             go_q;
    logic             ill_q;
    logic [7:0]       cnt_q;
    logic             pready_q;
    logic [31:0]      prdata_q;
    logic             pslverr_q;
    icl_pkg::icl_out_s ex;

    wire logic access   = psel & penable;
    wire logic done     = access & pready_q;
    wire logic wr_en    = done & pwrite;
    wire logic sel_a    = (paddr == icl_pkg::ADDR_OPND_A);
    wire logic sel_b    = (paddr == icl_pkg::ADDR_OPND_B);
    wire logic sel_cmd  = (paddr == icl_pkg::ADDR_CMD);
    wire logic sel_res  = (paddr == icl_pkg::ADDR_RESULT);
    wire logic sel_cond = (paddr == icl_pkg::ADDR_COND);
    wire logic sel_fx   = (paddr == icl_pkg::ADDR_FXER);
    wire logic sel_st   = (paddr == icl_pkg::ADDR_STATUS);
    wire logic hit      = sel_a | sel_b | sel_cmd | sel_res | sel_cond | sel_fx | sel_st;
    wire logic [31:0] status_w = {16'h0000, cnt_q, 7'h00, ill_q};
    wire logic [31:0] rd_mux   = sel_a    ? opnd_a_q :
                                 sel_b    ? opnd_b_q :
                                 sel_cmd  ? cmd_q :
                                 sel_res  ? result_q :
                                 sel_cond ? cond_reg_q :
                                 sel_fx   ? {29'h0000_0000, fxer_q} :
                                 sel_st   ? status_w : icl_pkg::RST_WORD;

    // one wait state so that read data and error come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= access & ~pready_q;
            prdata_q  <= (access & ~pready_q & ~pwrite) ? rd_mux : 32'h0000_0000;
            pslverr_q <= access & ~pready_q & ~hit;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ****************************************
    // operand and command registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opnd_a_q <= 32'h0000_0000;
            opnd_b_q <= 32'h0000_0000;
            cmd_q    <= '0;
            go_q     <= 1'b0;
        end else begin
            if (wr_en && sel_a) begin
                opnd_a_q <= pwdata;
            end
            if (wr_en && sel_b) begin
                opnd_b_q <= pwdata;
            end
            if (wr_en && sel_cmd) begin
                cmd_q <= pwdata;
            end
            go_q <= wr_en & sel_cmd;
        end
    end

    // ****************************************
    // datapath
    // ****************************************
    icl_exec u_exec (
        .cmd     (cmd_q),
        .opnd_a  (opnd_a_q),
        .opnd_b  (opnd_b_q),
        .so_flag (fxer_q[icl_pkg::FX_SO]),
        .res     (ex)
    );

    wire logic cf_upd = go_q & ex.cf_wr;

    // ****************************************
    // results, condition and exception registers
    // ****************************************
    // the operation lands one edge after the command write, so it never meets a
    // software write of the same register; hardware would win if it did
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q   <= 32'h0000_0000;
            cond_reg_q <= 32'h0000_0000;
            fxer_q     <= 3'h0;
            ill_q      <= 1'b0;
            cnt_q      <= 8'h00;
        end else begin
            if (go_q && ex.gpr_wr) begin
                result_q <= ex.result;
            end
            if (cf_upd) begin
                cond_reg_q <= icl_pkg::cf_put(cond_reg_q, ex.cf_sel, ex.cf_field);
            end else if (wr_en && sel_cond) begin
                cond_reg_q <= pwdata;
            end
            // only software writes these flags
            if (wr_en && sel_fx) begin
                fxer_q <= pwdata[2:0];
            end
            if (go_q) begin
                ill_q <= ex.illegal;
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire logic is_cmp_op = (cmd_q.op <= 4'h3);

    // one flag of one condition field, as the checks below read it
    function automatic logic cf_bit(input logic [31:0] cond, input logic [2:0] sel,
                                    input int pos);
        logic [3:0] fld;
        fld = icl_pkg::cf_get(cond, sel);
        return fld[pos];
    endfunction

    cmp_signed_a: assert property (go_q && cmd_q.op == 4'h1 |=>
        cf_bit(cond_reg_q, $past(cmd_q.sel), icl_pkg::CF_LT)
            == ($signed($past(opnd_a_q)) < $signed($past(opnd_b_q))))
        else $error("signed compare less-than wrong");

    cmpi_signed_a: assert property (go_q && cmd_q.op == 4'h0 |=>
        cf_bit(cond_reg_q, $past(cmd_q.sel), icl_pkg::CF_GT)
            == ($signed($past(opnd_a_q)) > $signed({{16{$past(cmd_q.imm[15])}},
                                                     $past(cmd_q.imm)})))
        else $error("signed immediate compare greater-than wrong");

    cmp_unsigned_a: assert property (go_q && cmd_q.op == 4'h3 |=>
        cf_bit(cond_reg_q, $past(cmd_q.sel), icl_pkg::CF_LT)
            == ($past(opnd_a_q) < $past(opnd_b_q)))
        else $error("unsigned compare less-than wrong");

    cmpli_zext_a: assert property (go_q && cmd_q.op == 4'h2 |=>
        cf_bit(cond_reg_q, $past(cmd_q.sel), icl_pkg::CF_GT)
            == ($past(opnd_a_q) > {16'h0000, $past(cmd_q.imm)}))
        else $error("unsigned immediate compare wrong");

    other_fields_a: assert property (go_q && is_cmp_op |=>
        (cond_reg_q & ~icl_pkg::cf_mask($past(cmd_q.sel)))
            == ($past(cond_reg_q) & ~icl_pkg::cf_mask($past(cmd_q.sel))))
        else $error("compare touched another field");

    full_width_a: assert property (go_q && cmd_q.op == 4'h1 |=>
        cf_bit(cond_reg_q, $past(cmd_q.sel), icl_pkg::CF_EQ)
            == ($past(opnd_a_q) == $past(opnd_b_q)))
        else $error("compare not over all 32 bits");

    field_select_a: assert property (go_q && is_cmp_op |-> ex.cf_sel == cmd_q.sel
        ##1 icl_pkg::cf_get(cond_reg_q, $past(cmd_q.sel)) == $past(ex.cf_field))
        else $error("compare field not at selector");

    andi_field_a: assert property (go_q && cmd_q.op == 4'h4 |=>
        cf_bit(cond_reg_q, 3'h0, icl_pkg::CF_EQ) == (result_q == 32'h0000_0000)
        && cf_bit(cond_reg_q, 3'h0, icl_pkg::CF_LT) == result_q[31])
        else $error("and-immediate field zero wrong");

    andis_field_a: assert property (go_q && cmd_q.op == 4'h5 |=>
        cf_bit(cond_reg_q, 3'h0, icl_pkg::CF_GT)
            == (result_q != 32'h0000_0000 && !result_q[31]))
        else $error("and-immediate-high field zero wrong");

    imm_no_cond_a: assert property (go_q && cmd_q.op >= 4'h6 && cmd_q.op <= 4'h9
        |=> $stable(cond_reg_q))
        else $error("immediate or/xor changed condition register");

    fxer_kept_a: assert property (go_q |=> $stable(fxer_q))
        else $error("operation changed exception flags");

    ori_result_a: assert property (go_q && cmd_q.op == 4'h6 |=>
        result_q == ($past(opnd_a_q) | {16'h0000, $past(cmd_q.imm)}))
        else $error("low immediate or result wrong");

    xoris_result_a: assert property (go_q && cmd_q.op == 4'h9 |=>
        result_q == ($past(opnd_a_q) ^ {$past(cmd_q.imm), 16'h0000}))
        else $error("high immediate xor result wrong");

    xor_result_a: assert property (go_q && cmd_q.op == 4'hc |=>
        result_q == ($past(opnd_a_q) ^ $past(opnd_b_q)))
        else $error("register xor result wrong");

    nor_result_a: assert property (go_q && cmd_q.op == 4'he |=>
        result_q == ~($past(opnd_a_q) | $past(opnd_b_q)))
        else $error("nor result wrong");

    record_off_a: assert property (go_q && cmd_q.op >= 4'ha && cmd_q.op <= 4'he
        && !cmd_q.rec |=> $stable(cond_reg_q))
        else $error("record bit clear but condition changed");

    record_on_a: assert property (go_q && cmd_q.op == 4'hd && cmd_q.rec |=>
        cf_bit(cond_reg_q, 3'h0, icl_pkg::CF_LT) == result_q[31])
        else $error("record bit set but field zero wrong");

    so_copy_a: assert property (go_q && ex.cf_wr |=>
        cf_bit(cond_reg_q, $past(ex.cf_sel), icl_pkg::CF_SO)
            == $past(fxer_q[icl_pkg::FX_SO]))
        else $error("field summary-overflow copy wrong");

    // bus side: exactly one wait state, answers stand one cycle
    one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("ready not one cycle after access");

    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready stood more than one cycle");

    err_ready_a: assert property (pslverr |-> pready)
        else $error("error raised without ready");

    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside a read answer");

endmodule // icl_unit

// *** hw/icl_pkg.sv ***
// package of constants, types and helpers for the integer compare and logic unit
package icl_pkg;

    // ****************************************
    // widths and register map
    // ****************************************
    localparam int          XLEN        = 32;
    localparam int          AW          = 8;
    localparam int          FIELD_W     = 4;
    localparam int          CF_COUNT    = 8;
    localparam logic [7:0]  ADDR_OPND_A = 8'h00;
    localparam logic [7:0]  ADDR_OPND_B = 8'h04;
    localparam logic [7:0]  ADDR_CMD    = 8'h08;
    localparam logic [7:0]  ADDR_RESULT = 8'h0c;
    localparam logic [7:0]  ADDR_COND   = 8'h10;
    localparam logic [7:0]  ADDR_FXER   = 8'h14;
    localparam logic [7:0]  ADDR_STATUS = 8'h18;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int          CF_LT       = 3;
    localparam int          CF_GT       = 2;
    localparam int          CF_EQ       = 1;
    localparam int          CF_SO       = 0;
    localparam int          FX_SO       = 2;
    localparam int          FX_EXC      = 1;
    localparam int          FX_SPILL    = 0;
    localparam int          FX_W        = 3;
    localparam int          ST_ILL      = 0;
    localparam int          ST_CNT_LSB  = 8;
    localparam int          ST_CNT_W    = 8;
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;
    localparam logic [15:0] HALF_ZERO   = 16'h0000;

    // ****************************************
    // operations, in command code order 0..14
    // ****************************************
    typedef enum logic [3:0] {
        ICL_OP_CMPI, ICL_OP_CMP, ICL_OP_CMPLI, ICL_OP_CMPL,
        ICL_OP_ANDI, ICL_OP_ANDIS, ICL_OP_ORI, ICL_OP_ORIS,
        ICL_OP_XORI, ICL_OP_XORIS, ICL_OP_AND, ICL_OP_OR,
        ICL_OP_XOR, ICL_OP_NAND, ICL_OP_NOR
    } icl_op_e;

    // command word as software writes it
    typedef struct packed {
        logic [15:0] imm;
        logic [6:0]  rsvd;
        logic        size;
        logic [2:0]  sel;
        logic        rec;
        logic [3:0]  op;
    } icl_cmd_s;

    // what one operation produces
    typedef struct packed {
        logic [31:0] result;
        logic        gpr_wr;
        logic        cf_wr;
        logic [2:0]  cf_sel;
        logic [3:0]  cf_field;
        logic        illegal;
    } icl_out_s;

    // field 0 sits in the top nibble
    function automatic logic [3:0] cf_get(input logic [31:0] cond, input logic [2:0] sel);
        return cond[(3'd7 - sel) * 4 +: 4];
    endfunction

    function automatic logic [31:0] cf_mask(input logic [2:0] sel);
        return 32'hf000_0000 >> ({2'b00, sel} * 5'd4);
    endfunction

    function automatic logic [31:0] cf_put(input logic [31:0] cond, input logic [2:0] sel,
                                           input logic [3:0] fld);
        return (cond & ~cf_mask(sel)) | ({fld, 28'h000_0000} >> ({2'b00, sel} * 5'd4));
    endfunction

endpackage

// *** hw/icl_exec.sv ***
// combinational compare and bitwise logic datapath
`timescale 1ns/1ns
module icl_exec (
    input  wire icl_pkg::icl_cmd_s cmd,      // decoded command word
    input  wire logic [31:0]       opnd_a,   // first source operand
    input  wire logic [31:0]       opnd_b,   // second source operand
    input  wire logic              so_flag,  // current summary-overflow flag
    output icl_pkg::icl_out_s      res       // result, targets and field
);
    wire logic [31:0] signed_imm16_ext = {{16{cmd.imm[15]}}, cmd.imm};
    wire logic [31:0] unsigned_imm16_lo  = {icl_pkg::HALF_ZERO, cmd.imm};
    wire logic [31:0] unsigned_imm16_hi  = {cmd.imm, icl_pkg::HALF_ZERO};
    wire icl_pkg::icl_op_e op  = icl_pkg::icl_op_e'(cmd.op);

    logic [31:0] word;
    logic [31:0] cmp_b;
    logic        is_cmp;
    logic        sgn;
    logic        gpr_wr;
    logic        cf_wr;
    logic        illegal;

    // one comparator serves compares and the test of a result against zero
    function automatic logic [3:0] cmp_field(input logic [31:0] a, input logic [31:0] b,
                                             input logic s, input logic so);
        logic lt;
        logic gt;
        lt = s ? ($signed(a) < $signed(b)) : (a < b);
        gt = s ? ($signed(a) > $signed(b)) : (a > b);
        return {lt, gt, (a == b), so};
    endfunction

    always_comb begin
        word    = icl_pkg::RST_WORD;
        cmp_b   = opnd_b;
        is_cmp  = 1'b0;
        sgn     = 1'b1;
        gpr_wr  = 1'b0;
        cf_wr   = 1'b0;
        illegal = 1'b0;
        // size bit is never looked at: every compare is full width
        unique case (op)
            icl_pkg::ICL_OP_CMPI: begin
                is_cmp = 1'b1;
                cmp_b  = signed_imm16_ext;
            end
            icl_pkg::ICL_OP_CMP: begin
                is_cmp = 1'b1;
            end
            icl_pkg::ICL_OP_CMPLI: begin
                is_cmp = 1'b1;
                sgn    = 1'b0;
                cmp_b  = unsigned_imm16_lo;
            end
            icl_pkg::ICL_OP_CMPL: begin
                is_cmp = 1'b1;
                sgn    = 1'b0;
            end
            icl_pkg::ICL_OP_ANDI: begin
                word  = opnd_a & unsigned_imm16_lo;
                cf_wr = 1'b1;
            end
            icl_pkg::ICL_OP_ANDIS: begin
                word  = opnd_a & unsigned_imm16_hi;
                cf_wr = 1'b1;
            end
            icl_pkg::ICL_OP_ORI:   word = opnd_a | unsigned_imm16_lo;
            icl_pkg::ICL_OP_ORIS:  word = opnd_a | unsigned_imm16_hi;
            icl_pkg::ICL_OP_XORI:  word = opnd_a ^ unsigned_imm16_lo;
            icl_pkg::ICL_OP_XORIS: word = opnd_a ^ unsigned_imm16_hi;
            icl_pkg::ICL_OP_AND: begin
                word  = opnd_a & opnd_b;
                cf_wr = cmd.rec;
            end
            icl_pkg::ICL_OP_OR: begin
                word  = opnd_a | opnd_b;
                cf_wr = cmd.rec;
            end
            icl_pkg::ICL_OP_XOR: begin
                word  = opnd_a ^ opnd_b;
                cf_wr = cmd.rec;
            end
            icl_pkg::ICL_OP_NAND: begin
                word  = ~(opnd_a & opnd_b);
                cf_wr = cmd.rec;
            end
            icl_pkg::ICL_OP_NOR: begin
                word  = ~(opnd_a | opnd_b);
                cf_wr = cmd.rec;
            end
            default: illegal = 1'b1;
        endcase
        if (is_cmp) begin
            cf_wr = 1'b1;
        end else if (!illegal) begin
            gpr_wr = 1'b1;
        end
    end

    assign res.result   = word;
    assign res.gpr_wr   = gpr_wr;
    assign res.cf_wr    = cf_wr;
    assign res.cf_sel   = is_cmp ? cmd.sel : 3'h0;
    // logical results are judged signed against zero, width is already 32
    assign res.cf_field = is_cmp ? cmp_field(opnd_a, cmp_b, sgn, so_flag)
                                 : cmp_field(word, icl_pkg::RST_WORD, 1'b1, so_flag);
    assign res.illegal  = illegal;

endmodule // icl_exec

// *** test/icl_apb_master.sv ***
// apb master model standing in for the software side of the unit
`timescale 1ns/1ns
module icl_apb_master (
    input  wire logic        pclk,     // core clock
    output logic             psel,     // apb select
    output logic             penable,  // apb access phase
    output logic             pwrite,   // apb direction
    output logic [7:0]       paddr,    // apb byte address
    output logic [31:0]      pwdata,   // apb write data
    input  wire logic [31:0] prdata,   // apb read data
    input  wire logic        pready,   // apb ready
    input  wire logic        pslverr   // apb error
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // ok stays low if no answer came within the bound
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic ok);
        ok = 1'b0;
        rd = 32'h0000_0000;
        err = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                ok = 1'b1;
                rd = prdata;
                err = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show garbage, not the last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // icl_apb_master

// *** test/tb_integer_compare_logic_unit.sv ***
// self-checking bench for the integer compare and logic unit
`timescale 1ns/1ns
module tb_integer_compare_logic_unit;
    typedef struct packed {
        logic [31:0] cmd;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] res;
        logic [31:0] cond;
        logic        chk;
    } icl_tb_row_s;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic        e;
    int          n_errors = 0;
    int          n_tests = 0;

    // ****************************************
    // ordinary cases; cond preset to 2222_2222, summary-overflow set
    // ****************************************
    icl_tb_row_s rows [16] = '{
        '{32'hffff_0180, 32'hffff_fffe, 32'h0000_0000, 32'h0, 32'h2222_9222, 1'b0},
        '{32'h0000_0001, 32'h0000_0001, 32'h8000_0000, 32'h0, 32'h5222_2222, 1'b0},
        '{32'hffff_00e2, 32'h0001_0000, 32'h0000_0000, 32'h0, 32'h2222_2225, 1'b0},
        '{32'h0000_0063, 32'h0000_0001, 32'h8000_0000, 32'h0, 32'h2229_2222, 1'b0},
        '{32'h0000_00a3, 32'h1234_5678, 32'h1234_5678, 32'h0, 32'h2222_2322, 1'b0},
        '{32'h8001_0064, 32'hffff_ffff, 32'h0, 32'h0000_8001, 32'h5222_2222, 1'b1},
        '{32'h8000_0005, 32'hffff_ffff, 32'h0, 32'h8000_0000, 32'h9222_2222, 1'b1},
        '{32'h00f0_0016, 32'h1200_000f, 32'h0, 32'h1200_00ff, 32'h2222_2222, 1'b1},
        '{32'h00f0_0007, 32'h0000_000f, 32'h0, 32'h00f0_000f, 32'h2222_2222, 1'b1},
        '{32'hffff_0008, 32'hffff_0000, 32'h0, 32'hffff_ffff, 32'h2222_2222, 1'b1},
        '{32'hffff_0009, 32'hffff_0000, 32'h0, 32'h0000_0000, 32'h2222_2222, 1'b1},
        '{32'h0000_001a, 32'hf0f0_f0f0, 32'hff00_ff00, 32'hf000_f000, 32'h9222_2222, 1'b1},
        '{32'h0000_000b, 32'hf0f0_0000, 32'h0f0f_0000, 32'hffff_0000, 32'h2222_2222, 1'b1},
        '{32'h0000_001c, 32'h5a5a_5a5a, 32'h5a5a_5a5a, 32'h0000_0000, 32'h3222_2222, 1'b1},
        '{32'h0000_001d, 32'hffff_ffff, 32'h7fff_ffff, 32'h8000_0000, 32'h9222_2222, 1'b1},
        '{32'h0000_000e, 32'h0000_0000, 32'h0000_0001, 32'hffff_fffe, 32'h2222_2222, 1'b1}
    };

    icl_unit dut (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    icl_apb_master m (
        .pclk    (pclk),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    always #2 pclk = ~pclk;

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // a hung bus ends the run through the closing report
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic ok;
        m.xfer(wr, a, d, r, e, ok);
        if (!ok) begin
            n_errors++;
            $display("ERROR apb no ready at %h", a);
            summarize();
        end
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            acc(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", r, 32'h0000_0000);
            chk("reset slverr", {31'h0, e}, 32'h0);
        end
        $display("test reset done");
        acc(1'b1, icl_pkg::ADDR_FXER, 32'h0000_0007);
        foreach (rows[i]) begin
            acc(1'b1, icl_pkg::ADDR_COND, 32'h2222_2222);
            acc(1'b1, icl_pkg::ADDR_OPND_A, rows[i].a);
            acc(1'b1, icl_pkg::ADDR_OPND_B, rows[i].b);
            acc(1'b1, icl_pkg::ADDR_CMD, rows[i].cmd);
            if (rows[i].chk) begin
                acc(1'b0, icl_pkg::ADDR_RESULT, 32'h0);
                chk("result", r, rows[i].res);
            end
            acc(1'b0, icl_pkg::ADDR_COND, 32'h0);
            chk("cond", r, rows[i].cond);
        end
        $display("test rows done");
        acc(1'b0, icl_pkg::ADDR_FXER, 32'h0);
        chk("fxer kept", r, 32'h0000_0007);
        acc(1'b0, icl_pkg::ADDR_STATUS, 32'h0);
        chk("status count", r, 32'h0000_1000);
        acc(1'b1, icl_pkg::ADDR_CMD, 32'h0000_001f);
        acc(1'b0, icl_pkg::ADDR_STATUS, 32'h0);
        chk("status illegal", r, 32'h0000_1101);
        acc(1'b0, icl_pkg::ADDR_COND, 32'h0);
        chk("cond after illegal", r, 32'h2222_2222);
        acc(1'b1, icl_pkg::ADDR_RESULT, 32'h0);
        acc(1'b0, icl_pkg::ADDR_RESULT, 32'h0);
        chk("result read only", r, 32'hffff_fffe);
        acc(1'b0, 8'h1c, 32'h0);
        chk("unmapped data", r, 32'h0000_0000);
        chk("unmapped slverr", {31'h0, e}, 32'h0000_0001);
        $display("test awkward done");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        acc(1'b0, icl_pkg::ADDR_COND, 32'h0);
        chk("cond after reset", r, 32'h0000_0000);
        acc(1'b0, icl_pkg::ADDR_RESULT, 32'h0);
        chk("result after reset", r, 32'h0000_0000);
        acc(1'b0, icl_pkg::ADDR_STATUS, 32'h0);
        chk("status after reset", r, 32'h0000_0000);
        acc(1'b0, icl_pkg::ADDR_FXER, 32'h0);
        chk("fxer after reset", r, 32'h0000_0000);
        $display("test mid reset done");
        summarize();
    end
endmodule // tb_integer_compare_logic_unit
